// File: verilog/cald_pkg.sv
// Shared constants, opcode fields and carrier types of the 8-bit core
package cald_pkg;
  // Reset values
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [7:0] RESET_ACC = 8'h00;
  // Oscillator periods in one machine cycle
  localparam logic [5:0] MCYCLE_PERIODS = 6'h0c;
  // Machine cycles per instruction
  localparam logic [2:0] MC_ONE = 3'h1;
  localparam logic [2:0] MC_TWO = 3'h2;
  // Instruction lengths in bytes
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  // Upper opcode nibble: operation group
  localparam logic [3:0] NIB_INC = 4'h0;
  localparam logic [3:0] NIB_DEC = 4'h1;
  localparam logic [3:0] NIB_ADD = 4'h2;
  localparam logic [3:0] NIB_ADD_WITH_CARRY = 4'h3;
  localparam logic [3:0] NIB_OR = 4'h4;
  localparam logic [3:0] NIB_AND = 4'h5;
  localparam logic [3:0] NIB_XOR = 4'h6;
  localparam logic [3:0] NIB_MOVI = 4'h7;
  localparam logic [3:0] NIB_MOVD = 4'h8;
  localparam logic [3:0] NIB_SUBTRACT_WITH_BORROW = 4'h9;
  localparam logic [3:0] NIB_MOVRD = 4'ha;
  localparam logic [3:0] NIB_MOVA = 4'he;
  localparam logic [3:0] NIB_MOVTA = 4'hf;
  // Lower opcode nibble: operand form
  localparam logic [3:0] LO_TODIR_A = 4'h2;
  localparam logic [3:0] LO_TODIR_IMM = 4'h3;
  localparam logic [3:0] LO_IMM = 4'h4;
  localparam logic [3:0] LO_DIR = 4'h5;
  localparam logic [2:0] IND_TAG = 3'h3;
  // Single-byte accumulator opcodes and the no-op
  localparam logic [7:0] OPC_NOP = 8'h00;
  localparam logic [7:0] OPC_RR = 8'h03;
  localparam logic [7:0] OPC_RRC = 8'h13;
  localparam logic [7:0] OPC_RL = 8'h23;
  localparam logic [7:0] OPC_RLC = 8'h33;
  localparam logic [7:0] OPC_SWAP = 8'hc4;
  localparam logic [7:0] OPC_CLR = 8'he4;
  localparam logic [7:0] OPC_CPL = 8'hf4;
  // Padding bits of bank and pointer register addresses
  localparam logic [2:0] BANK_PAD = 3'h0;
  localparam logic [1:0] PTR_PAD = 2'h0;
  // Internal RAM depth in bytes
  localparam int RAM_DEPTH = 256;
  // Operand sources, operations and destinations
  typedef enum logic [1:0] {RD_NONE, RD_REG, RD_DIR1, RD_IND} cald_rd_type;
  typedef enum logic [1:0] {B_ACC, B_RAM, B_IMM1, B_IMM2} cald_bsel_type;
  typedef enum logic [3:0] {
    ALU_PASS, ALU_ADD, ALU_ADD_WITH_CARRY, ALU_SUBTRACT_WITH_BORROW, ALU_AND, ALU_OR, ALU_XOR, ALU_INC,
    ALU_DEC, ALU_RL, ALU_RLC, ALU_RR, ALU_RRC, ALU_SWAP, ALU_CLR, ALU_CPL
  } cald_alu_type;
  typedef enum logic [1:0] {DST_NONE, DST_ACC, DST_RAM} cald_dst_type;
  typedef enum logic [1:0] {WA_REG, WA_DIR1, WA_DIR2, WA_IND} cald_wa_type;
  // Sequencer states, one-hot
  typedef enum logic [6:0] {
    ST_FETCH = 7'h01, ST_OPND1 = 7'h02, ST_OPND2 = 7'h04, ST_READ = 7'h08,
    ST_PTR = 7'h10, ST_EXEC = 7'h20, ST_HOLD = 7'h40
  } cald_state_type;
  // Decoded instruction
  typedef struct packed {
    logic legal;
    logic [1:0] len;
    logic [2:0] mcyc;
    cald_rd_type rd;
    logic aRam;
    cald_bsel_type bSel;
    cald_alu_type alu;
    cald_dst_type dst;
    cald_wa_type wa;
  } cald_dec_type;
  // RAM write request
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } cald_wr_type;
endpackage

// File: verilog/cald_ram.sv
// Internal data RAM with registered read ports
`timescale 1ns/1ns
`default_nettype none
module cald_ram
  import cald_pkg::*;
(
  input wire logic clk, // Oscillator clock
  input wire logic sys_rst, // Asynchronous reset
  input wire cald_wr_type wr, // Write request
  input wire logic [7:0] rdAddr, // Core read address
  output logic [7:0] rdData, // Core read data, one cycle later
  input wire logic [7:0] peekAddr, // Observation read address
  output logic [7:0] peekData // Observation read data
);
  logic [7:0] mem [0:RAM_DEPTH-1]; // Storage, not cleared by reset

  // Write port
  always_ff @(posedge clk) begin
    if (wr.we) begin
      mem[wr.addr] <= wr.data;
    end
  end

  // Read data registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData <= RESET_ACC;
      peekData <= RESET_ACC;
    end else begin
      rdData <= mem[rdAddr];
      peekData <= mem[peekAddr];
    end
  end
endmodule
`default_nettype wire

// File: verilog/cald_alu.sv
// Arithmetic, logic, rotate and move unit
`timescale 1ns/1ns
`default_nettype none
module cald_alu
  import cald_pkg::*;
(
  input wire cald_alu_type op, // Operation
  input wire logic [7:0] aVal, // First operand
  input wire logic [7:0] bVal, // Second operand
  input wire logic carryIn, // Current carry
  output logic [7:0] result, // Result byte
  output logic carryOut, // New carry
  output logic carryWe // Operation updates the carry
);
  logic [8:0] sumW; // Sum with carry out
  logic [8:0] diffW; // Difference with borrow out
  logic [8:0] calcW; // Carry and result

  // Carry enters only the add-with-carry sum
  assign sumW = {1'b0, aVal} + {1'b0, bVal} + {8'h00, (op == ALU_ADD_WITH_CARRY) & carryIn}; // see [RQ3]
  // Borrow is the current carry
  assign diffW = {1'b0, aVal} - {1'b0, bVal} - {8'h00, carryIn}; // see [RQ4]

  // Operation select, carry in the top bit; every operand is an argument so the result follows it
  function automatic logic [8:0] calc(input cald_alu_type o, input logic [7:0] a, input logic [7:0] b,
                                      input logic c, input logic [8:0] s, input logic [8:0] df);
    unique case (o)
      ALU_ADD, ALU_ADD_WITH_CARRY: calc = s; // see [RQ1] [RQ2]
      ALU_SUBTRACT_WITH_BORROW: calc = df;
      ALU_AND: calc = {c, a & b}; // see [RQ5] [RQ6]
      ALU_OR: calc = {c, a | b}; // see [RQ7]
      ALU_XOR: calc = {c, a ^ b}; // see [RQ8]
      ALU_INC: calc = {c, a + 8'h01};
      ALU_DEC: calc = {c, a - 8'h01};
      ALU_RL: calc = {c, a[6:0], a[7]};
      ALU_RLC: calc = {a[7], a[6:0], c}; // see [RQ9]
      ALU_RR: calc = {c, a[0], a[7:1]};
      ALU_RRC: calc = {a[0], c, a[7:1]}; // see [RQ10]
      ALU_SWAP: calc = {c, a[3:0], a[7:4]}; // see [RQ11]
      ALU_CLR: calc = {c, 8'h00};
      ALU_CPL: calc = {c, ~a};
      ALU_PASS: calc = {c, b};
    endcase
  endfunction

  assign calcW = calc(op, aVal, bVal, carryIn, sumW, diffW);
  assign result = calcW[7:0];
  assign carryOut = calcW[8];
  assign carryWe = (op == ALU_ADD) || (op == ALU_ADD_WITH_CARRY) || (op == ALU_SUBTRACT_WITH_BORROW) || (op == ALU_RLC) || (op == ALU_RRC);
endmodule
`default_nettype wire

// File: verilog/cald_core.sv
// Sequencer, decoder and datapath of the 8-bit core
`timescale 1ns/1ns
`default_nettype none
// Function
// [RQ1] Add register or indirect: 1 byte, 12
// [RQ2] Add direct or immediate: 2 bytes, 12
// [RQ3] Add with carry, same forms and timing
// [RQ4] Subtract with borrow: 1/2 bytes, 12
// [RQ5] AND immediate into direct: 3 bytes, 24
// [RQ6] AND accumulator into direct: 2 bytes, 12
// [RQ7] OR has AND forms; accumulator forms 12
// [RQ8] XOR immediate/direct 3/24; accumulator/direct 2/12
// [RQ9] Rotate left through carry: 1 byte, 12
// [RQ10] Rotate right through carry: 1 byte, 12
// [RQ11] Swap accumulator nibbles: 1 byte, 12
// [RQ12] Immediate into accumulator: 2 bytes, 12
// [RQ13] Direct to register 2/24; immediate 2/12
// [RQ14] Register to direct: 2 bytes, 24
// [RQ15] Direct to direct: 3 bytes, 24
// [RQ16] Indirect to direct: 2 bytes, 24
// [RQ17] Twelve periods form one machine cycle
// [RQ18] Fetch all operands before next opcode
module cald_core
  import cald_pkg::*;
(
  input wire logic clk, // Oscillator clock
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic [7:0] codeData, // Program memory byte at codeAddr
  input wire logic [1:0] bankSelect, // Active register bank
  input wire logic [7:0] peekAddr, // RAM observation address
  output logic [15:0] codeAddr, // Program memory address
  output logic codeFetch, // Byte at codeAddr taken this cycle
  output logic [7:0] accOut, // Accumulator
  output logic carryOut, // Carry flag
  output logic instrDone, // Instruction finished, one cycle
  output logic illegalOp, // Finished instruction was undecoded
  output logic [7:0] peekData // RAM byte at peekAddr, one cycle later
);

  // Sequencer and datapath registers
  cald_state_type state_q; // Current sequencer state
  cald_state_type state_d; // Next sequencer state
  logic [5:0] cnt_q; // Oscillator periods into the instruction
  logic [15:0] pc_q; // Program counter
  logic [7:0] opcode_q; // Opcode byte
  logic [7:0] imm1_q; // First operand byte
  logic [7:0] imm2_q; // Second operand byte
  logic [7:0] ptr_q; // Pointer fetched for indirect access
  logic [7:0] acc_q; // Accumulator
  logic carry_q; // Carry flag
  logic done_q; // Instruction end pulse
  logic illegal_q; // Undecoded instruction pulse

  // Decode and datapath wires
  cald_dec_type dec; // Decoded opcode
  cald_wr_type ramWr; // RAM write request
  logic [5:0] periodTotal; // Periods the instruction takes
  logic [5:0] lastCount; // Final period count
  logic lastHit; // Final period reached
  logic takeOpcode; // Opcode byte taken
  logic takeOp1; // First operand byte taken
  logic takeOp2; // Second operand byte taken
  logic anyTake; // Any program byte taken
  logic [7:0] regAddr; // Bank register address
  logic [7:0] ptrAddr; // Pointer register address
  logic [7:0] readSel; // First RAM read address
  logic [7:0] ramRdAddr; // RAM read address
  logic [7:0] ramRdata; // RAM read data
  logic [7:0] aVal; // First operand to the unit
  logic [7:0] bVal; // Second operand to the unit
  logic [7:0] aluResult; // Result byte
  logic aluCarry; // New carry
  logic aluCarryWe; // Carry updated by this operation
  logic inExec; // Execute state
  logic [7:0] writeAddr; // RAM write address

  // Opcode decode: length, machine cycles, sources and destination
  function automatic cald_dec_type decodeOp(input logic [7:0] op);
    cald_dec_type d;
    logic [3:0] hi;
    logic [3:0] lo;
    logic isReg;
    logic isInd;
    logic isDir;
    logic isImm;
    logic isForm;
    cald_rd_type rdForm;
    logic [1:0] formLen;
    d = '{legal: 1'b0, len: LEN_1, mcyc: MC_ONE, rd: RD_NONE, aRam: 1'b0,
          bSel: B_ACC, alu: ALU_PASS, dst: DST_NONE, wa: WA_REG};
    hi = op[7:4];
    lo = op[3:0];
    isReg = op[3];
    isInd = (op[3:1] == IND_TAG);
    isDir = (lo == LO_DIR);
    isImm = (lo == LO_IMM);
    isForm = isReg || isInd || isDir || isImm;
    rdForm = isReg ? RD_REG : (isInd ? RD_IND : (isDir ? RD_DIR1 : RD_NONE));
    // Direct and immediate forms carry one operand byte
    formLen = (isDir || isImm) ? LEN_2 : LEN_1; // see [RQ1] [RQ2] [RQ4] [RQ7]
    if (isForm && op != OPC_CLR &&
        (hi == NIB_ADD || hi == NIB_ADD_WITH_CARRY || hi == NIB_SUBTRACT_WITH_BORROW || hi == NIB_OR ||
         hi == NIB_AND || hi == NIB_XOR || hi == NIB_MOVA)) begin
      // Accumulator destination, one machine cycle
      d.legal = 1'b1;
      d.len = formLen;
      d.rd = rdForm;
      d.bSel = isImm ? B_IMM1 : B_RAM;
      d.dst = DST_ACC;
      unique case (hi)
        NIB_ADD: d.alu = ALU_ADD; // see [RQ1] [RQ2]
        NIB_ADD_WITH_CARRY: d.alu = ALU_ADD_WITH_CARRY; // see [RQ3]
        NIB_SUBTRACT_WITH_BORROW: d.alu = ALU_SUBTRACT_WITH_BORROW; // see [RQ4]
        NIB_OR: d.alu = ALU_OR; // see [RQ7]
        NIB_AND: d.alu = ALU_AND;
        NIB_XOR: d.alu = ALU_XOR;
        default: d.alu = ALU_PASS;
      endcase
    end else if ((hi == NIB_OR || hi == NIB_AND || hi == NIB_XOR) &&
                 (lo == LO_TODIR_A || lo == LO_TODIR_IMM)) begin
      // Logic into a direct byte, written back there
      d.legal = 1'b1;
      d.rd = RD_DIR1;
      d.aRam = 1'b1;
      d.dst = DST_RAM;
      d.wa = WA_DIR1;
      d.alu = (hi == NIB_OR) ? ALU_OR : ((hi == NIB_AND) ? ALU_AND : ALU_XOR);
      if (lo == LO_TODIR_A) begin
        d.len = LEN_2; // see [RQ6] [RQ8]
        d.bSel = B_ACC;
      end else begin
        d.len = LEN_3; // see [RQ5] [RQ8]
        d.mcyc = MC_TWO;
        d.bSel = B_IMM2;
      end
    end else if ((hi == NIB_INC || hi == NIB_DEC) && isForm) begin
      // Step up or down in place; immediate slot names the accumulator
      d.legal = 1'b1;
      d.len = isDir ? LEN_2 : LEN_1;
      d.alu = (hi == NIB_INC) ? ALU_INC : ALU_DEC;
      if (isImm) begin
        d.dst = DST_ACC;
      end else begin
        d.aRam = 1'b1;
        d.rd = rdForm;
        d.dst = DST_RAM;
        d.wa = isReg ? WA_REG : (isInd ? WA_IND : WA_DIR1);
      end
    end else if (hi == NIB_MOVI && (isImm || isDir || isReg)) begin
      // Immediate data to accumulator, direct byte or bank register
      d.legal = 1'b1;
      d.len = isDir ? LEN_3 : LEN_2; // see [RQ12] [RQ13]
      d.mcyc = isDir ? MC_TWO : MC_ONE;
      d.bSel = isDir ? B_IMM2 : B_IMM1;
      d.dst = isImm ? DST_ACC : DST_RAM;
      d.wa = isDir ? WA_DIR1 : WA_REG;
    end else if (hi == NIB_MOVD && (isDir || isInd || isReg)) begin
      // Copy into a direct byte from direct, indirect or register
      d.legal = 1'b1;
      d.len = isDir ? LEN_3 : LEN_2; // see [RQ14] [RQ15] [RQ16]
      d.mcyc = MC_TWO;
      d.rd = rdForm;
      d.bSel = B_RAM;
      d.dst = DST_RAM;
      d.wa = isDir ? WA_DIR2 : WA_DIR1;
    end else if (hi == NIB_MOVRD && isReg) begin
      // Direct byte into a bank register
      d.legal = 1'b1;
      d.len = LEN_2; // see [RQ13]
      d.mcyc = MC_TWO;
      d.rd = RD_DIR1;
      d.bSel = B_RAM;
      d.dst = DST_RAM;
      d.wa = WA_REG;
    end else if (hi == NIB_MOVTA && (isDir || isReg)) begin
      // Accumulator into a direct byte or bank register
      d.legal = 1'b1;
      d.len = isDir ? LEN_2 : LEN_1;
      d.dst = DST_RAM;
      d.wa = isDir ? WA_DIR1 : WA_REG;
    end else begin
      // Single-byte accumulator operations and the no-op
      d.legal = 1'b1;
      d.dst = DST_ACC;
      if (op == OPC_RLC) begin
        d.alu = ALU_RLC; // see [RQ9]
      end else if (op == OPC_RRC) begin
        d.alu = ALU_RRC; // see [RQ10]
      end else if (op == OPC_SWAP) begin
        d.alu = ALU_SWAP; // see [RQ11]
      end else if (op == OPC_RL) begin
        d.alu = ALU_RL;
      end else if (op == OPC_RR) begin
        d.alu = ALU_RR;
      end else if (op == OPC_CLR) begin
        d.alu = ALU_CLR;
      end else if (op == OPC_CPL) begin
        d.alu = ALU_CPL;
      end else begin
        d.legal = (op == OPC_NOP);
        d.dst = DST_NONE;
      end
    end
    return d;
  endfunction

  // Decode the latched opcode
  assign dec = decodeOp(opcode_q);

  // Instruction time as whole machine cycles
  assign periodTotal = 6'(dec.mcyc * MCYCLE_PERIODS); // see [RQ17]
  assign lastCount = periodTotal - 6'h01;
  assign lastHit = (cnt_q == lastCount);

  // Program byte taking
  assign takeOpcode = (state_q == ST_FETCH);
  assign takeOp1 = (state_q == ST_OPND1) && (dec.len != LEN_1);
  assign takeOp2 = (state_q == ST_OPND2);
  assign anyTake = takeOpcode || takeOp1 || takeOp2;
  assign codeFetch = anyTake && !sys_rst;
  assign codeAddr = pc_q;

  // Register and pointer addresses in the active bank
  assign regAddr = {BANK_PAD, bankSelect, opcode_q[2:0]};
  assign ptrAddr = {BANK_PAD, bankSelect, PTR_PAD, opcode_q[0]};

  // RAM read: first the source or pointer, then the pointed byte
  assign readSel = (dec.rd == RD_DIR1) ? imm1_q : ((dec.rd == RD_IND) ? ptrAddr : regAddr);
  assign ramRdAddr = (state_q == ST_PTR) ? ramRdata : readSel;

  // Operand selection
  assign aVal = dec.aRam ? ramRdata : acc_q;
  assign bVal = (dec.bSel == B_RAM) ? ramRdata :
                ((dec.bSel == B_IMM1) ? imm1_q : ((dec.bSel == B_IMM2) ? imm2_q : acc_q));

  // Result write to RAM at the decoded destination
  assign inExec = (state_q == ST_EXEC);
  assign writeAddr = (dec.wa == WA_DIR1) ? imm1_q :
                     ((dec.wa == WA_DIR2) ? imm2_q : ((dec.wa == WA_IND) ? ptr_q : regAddr));
  assign ramWr = '{we: inExec && (dec.dst == DST_RAM), addr: writeAddr, data: aluResult}; // see [RQ5] [RQ6] [RQ14]

  // Operation unit
  cald_alu u_alu (
    .op(dec.alu),
    .aVal(aVal),
    .bVal(bVal),
    .carryIn(carry_q),
    .result(aluResult),
    .carryOut(aluCarry),
    .carryWe(aluCarryWe)
  );

  // Internal RAM holding banks and direct bytes
  cald_ram u_ram (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr(ramWr),
    .rdAddr(ramRdAddr),
    .rdData(ramRdata),
    .peekAddr(peekAddr),
    .peekData(peekData)
  );

  // Next sequencer state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_FETCH: state_d = ST_OPND1;
      // Third byte precedes any execution
      ST_OPND1: state_d = (dec.len == LEN_3) ? ST_OPND2 : ST_READ; // see [RQ18]
      ST_OPND2: state_d = ST_READ;
      // Indirect forms read the pointer first
      ST_READ: state_d = (dec.rd == RD_IND) ? ST_PTR : ST_EXEC;
      ST_PTR: state_d = ST_EXEC;
      ST_EXEC: state_d = ST_HOLD;
      // Next opcode only once the full time has passed
      ST_HOLD: state_d = lastHit ? ST_FETCH : ST_HOLD; // see [RQ17] [RQ18]
    endcase
  end

  // Sequencer state and period counter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_FETCH;
      cnt_q <= 6'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= (state_q == ST_HOLD && lastHit) ? 6'h00 : cnt_q + 6'h01;
    end
  end

  // Program counter and instruction bytes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc_q <= RESET_PC;
      opcode_q <= OPC_NOP;
      imm1_q <= 8'h00;
      imm2_q <= 8'h00;
    end else begin
      pc_q <= anyTake ? pc_q + 16'h0001 : pc_q; // see [RQ18]
      opcode_q <= takeOpcode ? codeData : opcode_q;
      imm1_q <= takeOp1 ? codeData : imm1_q;
      imm2_q <= takeOp2 ? codeData : imm2_q;
    end
  end

  // Pointer for indirect writes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_q <= 8'h00;
    end else if (state_q == ST_PTR) begin
      ptr_q <= ramRdata;
    end
  end

  // Accumulator and carry update at execution
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_q <= RESET_ACC;
      carry_q <= 1'b0;
    end else begin
      acc_q <= (inExec && dec.dst == DST_ACC) ? aluResult : acc_q; // see [RQ3] [RQ9] [RQ11] [RQ12]
      carry_q <= (inExec && aluCarryWe) ? aluCarry : carry_q; // see [RQ3] [RQ4] [RQ9] [RQ10]
    end
  end

  // End-of-instruction pulses
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_q <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      done_q <= (state_q == ST_HOLD) && lastHit;
      illegal_q <= (state_q == ST_HOLD) && lastHit && !dec.legal;
    end
  end

  // Registered status outputs
  assign accOut = acc_q;
  assign carryOut = carry_q;
  assign instrDone = done_q;
  assign illegalOp = illegal_q;
endmodule
`default_nettype wire

// File: verilog/placeholder_none.sv
// Empty compilation unit kept for file ordering
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// File: test/cald_prog_mem.sv
// Program memory model: combinational code store feeding the core
`timescale 1ns/1ns
`default_nettype none
module cald_prog_mem (
  input wire logic clk, // Core clock
  input wire logic [15:0] codeAddr, // Byte address
  input wire logic codeFetch, // Core takes a byte this cycle
  output logic [7:0] codeData // Byte at codeAddr
);
  // Code image, loaded by the bench before reset ends; unused space holds no-ops
  logic [7:0] mem [256] = '{default: 8'h00};
  // Last byte handed over
  logic [7:0] lastByte_q;
  // Byte in the cycle of its address; between fetches the bus shows the inverse of the last byte
  assign codeData = codeFetch ? mem[codeAddr[7:0]] : ~lastByte_q;
  // Remember the byte just taken
  always_ff @(posedge clk) begin
    if (codeFetch) begin
      lastByte_q <= codeData;
    end
  end
endmodule
`default_nettype wire

// File: test/cald_core_monitor.sv
// Concurrent checks on the ports of the 8-bit core
`timescale 1ns/1ns
`default_nettype none
module cald_core_monitor (
  input wire logic clk, // Oscillator clock
  input wire logic sys_rst, // Asynchronous reset
  input wire logic [15:0] codeAddr, // Program address
  input wire logic codeFetch, // Byte taken
  input wire logic [7:0] accOut, // Accumulator
  input wire logic carryOut, // Carry
  input wire logic instrDone, // End of instruction
  input wire logic illegalOp // Undecoded opcode
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Cycles since the last instruction boundary, saturating
  logic [7:0] gap_q;
  logic [7:0] gap_d;
  assign gap_d = instrDone ? 8'h01 : ((gap_q == 8'hff) ? gap_q : gap_q + 8'h01);
  // Restarts at reset and at each boundary
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_q <= 8'h00;
    end else begin
      gap_q <= gap_d;
    end
  end
  property p_startFetch;
    $fell(sys_rst) |-> codeFetch && codeAddr == 16'h0000;
  endproperty
  a_startFetch: assert property (p_startFetch) else $error("No fetch at zero after reset");
  property p_doneGap;
    instrDone |-> (gap_q == 8'h0c || gap_q == 8'h18);
  endproperty
  a_doneGap: assert property (p_doneGap) else $error("Instruction time not 12 or 24");
  property p_doneFetch;
    instrDone |-> codeFetch;
  endproperty
  a_doneFetch: assert property (p_doneFetch) else $error("Boundary without opcode fetch");
  property p_pcStep;
    codeFetch |=> codeAddr == $past(codeAddr) + 16'h0001;
  endproperty
  a_pcStep: assert property (p_pcStep) else $error("Address did not advance after fetch");
  property p_pcHold;
    !codeFetch |=> $stable(codeAddr);
  endproperty
  a_pcHold: assert property (p_pcHold) else $error("Address moved without fetch");
  property p_burst;
    codeFetch [*3] |=> !codeFetch;
  endproperty
  a_burst: assert property (p_burst) else $error("More than three bytes fetched in a row");
  property p_backToBack;
    codeFetch && !instrDone && !$past(sys_rst) |-> $past(codeFetch);
  endproperty
  a_backToBack: assert property (p_backToBack) else $error("Operand byte not adjacent");
  property p_accSettle;
    $changed(accOut) |-> !instrDone [*7];
  endproperty
  a_accSettle: assert property (p_accSettle) else $error("Accumulator changed near boundary");
  property p_carrySettle;
    $changed(carryOut) |=> !instrDone [*6];
  endproperty
  a_carrySettle: assert property (p_carrySettle) else $error("Carry changed near boundary");
  property p_illegalPair;
    illegalOp |-> instrDone;
  endproperty
  a_illegalPair: assert property (p_illegalPair) else $error("Undecoded flag off boundary");
endmodule
bind cald_core cald_core_monitor i_cald_core_monitor (.clk(clk), .sys_rst(sys_rst), .codeAddr(codeAddr),
  .codeFetch(codeFetch), .accOut(accOut), .carryOut(carryOut), .instrDone(instrDone), .illegalOp(illegalOp));
`default_nettype wire

// File: test/tb_top.sv
// Self-checking testbench of the 8-bit core with a program memory model
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // Row: code bytes, length, periods, accumulator, carry, peek address, peek byte
  typedef struct packed {
    logic [23:0] code;
    logic [3:0] len;
    logic [7:0] per;
    logic [7:0] acc;
    logic [3:0] cy;
    logic [7:0] pk;
    logic [7:0] pv;
  } cald_row_type;
  logic clk; // Oscillator clock
  logic sys_rst; // Reset, active high
  logic [1:0] bankSelect; // Register bank
  logic [7:0] peekAddr; // Observed RAM address
  logic [7:0] codeData; // Program byte
  logic [15:0] codeAddr; // Program address
  logic codeFetch; // Byte taken
  logic [7:0] accOut; // Accumulator
  logic carryOut; // Carry
  logic instrDone; // Instruction boundary
  logic illegalOp; // Undecoded opcode
  logic [7:0] peekData; // Observed RAM byte
  int errCount = 0; // Mismatches
  int compares = 0; // Comparisons
  logic [15:0] nextAddr; // Expected next opcode address
  // Program in order, with results after each instruction
  cald_row_type rows [27] = '{64'h7530c3_3_18_00_0_30_c3, 64'h745a00_2_0c_5a_0_30_c3, 64'h788100_2_0c_5a_0_00_81,
    64'h793000_2_0c_5a_0_01_30, 64'h280000_1_0c_db_0_30_c3, 64'h253000_2_0c_9e_1_30_c3,
    64'h370000_1_0c_62_1_30_c3, 64'h340f00_2_0c_72_0_30_c3, 64'h970000_1_0c_af_1_30_c3,
    64'h940e00_2_0c_a0_0_30_c3, 64'h953000_2_0c_dd_1_30_c3, 64'h980000_1_0c_5b_0_30_c3,
    64'h523000_2_0c_5b_0_30_43, 64'h53300f_3_18_5b_0_30_03, 64'h4330f0_3_18_5b_0_30_f3,
    64'h442400_2_0c_7f_0_30_f3, 64'h470000_1_0c_ff_0_30_f3, 64'h623000_2_0c_ff_0_30_0c,
    64'h6330ff_3_18_ff_0_30_f3, 64'h745a00_2_0c_5a_0_30_f3, 64'hc40000_1_0c_a5_0_30_f3,
    64'h330000_1_0c_4a_1_30_f3, 64'h130000_1_0c_a5_0_30_f3, 64'ha83000_2_18_a5_0_00_f3,
    64'h883200_2_18_a5_0_32_f3, 64'h850133_3_18_a5_0_33_30, 64'h873400_2_18_a5_0_34_f3};
  cald_prog_mem i_cald_prog_mem (.clk(clk), .codeAddr(codeAddr), .codeFetch(codeFetch), .codeData(codeData));
  cald_core i_cald_core (.clk(clk), .sys_rst(sys_rst), .codeData(codeData), .bankSelect(bankSelect),
    .peekAddr(peekAddr), .codeAddr(codeAddr), .codeFetch(codeFetch), .accOut(accOut), .carryOut(carryOut),
    .instrDone(instrDone), .illegalOp(illegalOp), .peekData(peekData));
  // Clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever begin
      #50 clk = ~clk;
    end
  end
  // Compare a value of up to 16 bits
  task automatic cmp_val(input string what, input logic [15:0] expV, input logic [15:0] gotV);
    compares++;
    if (gotV !== expV) begin
      errCount++;
      $display("Error %s expected %h seen %h", what, expV, gotV);
    end
  endtask
  // Compare a flag
  task automatic cmp_bit(input string what, input logic expV, input logic gotV);
    compares++;
    if (gotV !== expV) begin
      errCount++;
      $display("Error %s expected %b seen %b", what, expV, gotV);
    end
  endtask
  // Wait for the next boundary, then check instruction time and length
  task automatic step(input logic [15:0] expAddr, input logic [7:0] expPer);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (instrDone !== 1'b1 && n < 100);
    cmp_val("cycles", {8'h00, expPer}, n[15:0]);
    cmp_val("codeAddr", expAddr, codeAddr);
  endtask
  // Verdict and end of run
  task automatic closeOut;
    if (errCount == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Cut a hang short
  initial begin
    #200000;
    errCount++;
    closeOut;
  end
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    bankSelect = 2'h0;
    peekAddr = 8'h30;
    nextAddr = 16'h0000;
    // Lay code out back to back, then an undecoded byte and a bank-one register load
    foreach (rows[i]) begin
      for (int b = 0; b < rows[i].len; b++) begin
        i_cald_prog_mem.mem[nextAddr[7:0]] = rows[i].code[23 - 8 * b -: 8];
        nextAddr++;
      end
    end
    i_cald_prog_mem.mem[nextAddr[7:0]] = 8'ha5;
    i_cald_prog_mem.mem[nextAddr[7:0] + 8'h01] = 8'h78;
    i_cald_prog_mem.mem[nextAddr[7:0] + 8'h02] = 8'h44;
    nextAddr = 16'h0000;
    repeat (8) @(posedge clk);
    #1 sys_rst = 1'b0;
    // Table of ordinary instructions
    foreach (rows[i]) begin
      peekAddr = rows[i].pk;
      nextAddr = nextAddr + {12'h000, rows[i].len};
      step(nextAddr, rows[i].per);
      cmp_val("accOut", {8'h00, rows[i].acc}, {8'h00, accOut});
      cmp_bit("carryOut", rows[i].cy[0], carryOut);
      cmp_val("peekData", {8'h00, rows[i].pv}, {8'h00, peekData});
    end
    // Undecoded opcode: one byte, one machine cycle, no effect
    nextAddr = nextAddr + 16'h0001;
    step(nextAddr, 8'h0c);
    cmp_bit("illegalOp", 1'b1, illegalOp);
    cmp_val("accOut", 16'h00a5, {8'h00, accOut});
    // Register load lands in bank one
    bankSelect = 2'h1;
    peekAddr = 8'h08;
    nextAddr = nextAddr + 16'h0002;
    step(nextAddr, 8'h0c);
    cmp_val("peekData", 16'h0044, {8'h00, peekData});
    // Reset in mid-run clears the core and restarts at address zero
    @(posedge clk);
    #1 sys_rst = 1'b1;
    @(posedge clk);
    #1;
    cmp_val("codeAddr", 16'h0000, codeAddr);
    cmp_val("accOut", 16'h0000, {8'h00, accOut});
    cmp_bit("codeFetch", 1'b0, codeFetch);
    cmp_bit("carryOut", 1'b0, carryOut);
    cmp_bit("instrDone", 1'b0, instrDone);
    @(posedge clk);
    #1 sys_rst = 1'b0;
    step(16'h0003, 8'h18);
    closeOut;
  end
endmodule
`default_nettype wire
